/* rtl/capture_trigger_map.vh */
`ifndef CAPTURE_TRIGGER_MAP_VH
`define CAPTURE_TRIGGER_MAP_VH
`define MODE_CAPTURE 2'b01
`define GRP_EXT_TIMER 1'b0
`define GRP_UNIT 1'b1
`define SRC_TIMER_BASE 5'h08
`define EDGE_RISE_RISE 2'b00
`define EDGE_RISE_FALL 2'b01
`define EDGE_FALL_RISE 2'b10
`define EDGE_FALL_FALL 2'b11
`define ESTOP_CMP0 2'b00
`define ESTOP_CMP1 2'b01
`define ESTOP_EXT_IRQ_LINE0 2'b10
`define ESTOP_EXI4 2'b11
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`endif

/* rtl/capture_trigger_control.v */
// What this block does
// (R01) mode 01b selects capture mode
// (R02) group 0 code 00H picks line 0
// (R03) start and stop each need enable bit
// (R04) edge mode 00b: start and stop rising
// (R05) event triggers act only with operation enable
// (R06) rising edge starts the counter
// (R07) falling edge latches capture B
// (R08) next rising stops, raises stop interrupt
// (R09) stopping rising edge latches capture A
// (R10) auto mode: restart, keep updating captures
// (R11) single mode: skip falling update after restart
// (R12) separate event and emergency-stop triggers
// (R13) event source among twenty inputs
// (R14) emergency stop halts counter, outputs low
// (R15) emergency source among four inputs
// (R16) interrupt controller feeds filtered lines
// (R17) comparators feed sampled outputs
// (R18) counter steps on counter clock, synced
// (R19) capture status clears by write or read
// (R20) rising stores A, falling stores B
// (R21) unread-capture flags set on latch
`timescale 1ns/10ps
`default_nettype none
`include "capture_trigger_map.vh"
module capture_trigger_control (
    // clock and reset
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    // configuration
    input wire [1:0] i_counter_mode_field,
    input wire i_one_shot_sel,
    input wire i_trig_src_group_sel,
    input wire [4:0] i_trig_src_code,
    input wire i_trig_start_en,
    input wire i_trig_stop_en,
    input wire [1:0] i_trig_edge_mode,
    input wire i_trig_op_en,
    input wire i_trig_stop_irq_en,
    input wire i_estop_en,
    input wire [1:0] i_estop_src_sel,
    input wire i_counter_clk,
    // software strobes
    input wire i_capture_a_irq_clr,
    input wire i_capture_b_irq_clr,
    input wire i_capture_a_read,
    input wire i_capture_b_read,
    input wire i_trig_stop_irq_clr,
    input wire i_estop_clr,
    // trigger sources
    input wire [7:0] i_ext_irq_trig,
    input wire [7:0] i_timer_irq_trig,
    input wire [3:0] i_unit_trig,
    input wire i_comparator0_trig,
    input wire i_comparator1_trig,
    // results
    output reg [15:0] o_capture_a_reg,
    output reg [15:0] o_capture_b_reg,
    output reg o_capture_a_flag,
    output reg o_capture_b_flag,
    output reg o_capture_a_irq,
    output reg o_capture_b_irq,
    output reg o_trig_stop_irq,
    output reg o_estop_irq,
    output reg o_running,
    output reg [15:0] o_count,
    output reg o_out_positive,
    output reg o_out_negative
);
    // external lines pass two flops; internal timer/unit triggers do not
    reg [7:0] ext_s1_q, ext_s2_q;
    reg cmp_s1_q, cmp_s2_q, cmp1_s1_q, cmp1_s2_q;
    reg ck_s1_q, ck_s2_q, ck_s3_q;
    reg ev_q, es_q;
    reg skip_b_q;
    reg ev_d, es_d;
    wire ev_rise, ev_fall, es_rise, ck_fall, start_edge, stop_edge;
    wire cap_mode;

    // event source: 0..7 ext, 8..15 timer irq in group 0; group 1 picks a unit
    function sel_event;
        input grp;
        input [4:0] code;
        input [7:0] ext;
        input [7:0] tmr;
        input [3:0] unit;
        begin
            if (grp == `GRP_UNIT)
                sel_event = unit[code[1:0]];
            else if (code < `SRC_TIMER_BASE)
                sel_event = ext[code[2:0]];
            else
                sel_event = tmr[code[2:0]];
        end
    endfunction

    always @* begin
        ev_d = sel_event(i_trig_src_group_sel, i_trig_src_code, ext_s2_q,
                         i_timer_irq_trig, i_unit_trig); // [R02] [R13] [R16]
        case (i_estop_src_sel) // [R15] [R17]
            `ESTOP_CMP0: es_d = cmp_s2_q;
            `ESTOP_CMP1: es_d = cmp1_s2_q;
            `ESTOP_EXT_IRQ_LINE0: es_d = ext_s2_q[0];
            `ESTOP_EXI4: es_d = ext_s2_q[4];
            default: es_d = 1'b0;
        endcase
    end

    assign ev_rise = ev_d & ~ev_q;
    assign ev_fall = ~ev_d & ev_q;
    assign es_rise = es_d & ~es_q;
    assign ck_fall = ck_s3_q & ~ck_s2_q; // [R18]
    assign cap_mode = (i_counter_mode_field == `MODE_CAPTURE); // [R01]
    // bit1 picks start edge, bit0 stop edge; 0 means rising
    assign start_edge = i_trig_edge_mode[1] ? ev_fall : ev_rise; // [R04]
    assign stop_edge = i_trig_edge_mode[0] ? ev_fall : ev_rise; // [R04]

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_s1_q <= 8'h00;
            ext_s2_q <= 8'h00;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            cmp1_s1_q <= 1'b0;
            cmp1_s2_q <= 1'b0;
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            ev_q <= 1'b0;
            es_q <= 1'b0;
            skip_b_q <= 1'b0;
            o_capture_a_reg <= `CNT_ZERO;
            o_capture_b_reg <= `CNT_ZERO;
            o_capture_a_flag <= 1'b0;
            o_capture_b_flag <= 1'b0;
            o_capture_a_irq <= 1'b0;
            o_capture_b_irq <= 1'b0;
            o_trig_stop_irq <= 1'b0;
            o_estop_irq <= 1'b0;
            o_running <= 1'b0;
            o_count <= `CNT_ZERO;
            o_out_positive <= 1'b0;
            o_out_negative <= 1'b0;
        end else if (i_ce) begin
            ext_s1_q <= i_ext_irq_trig;
            ext_s2_q <= ext_s1_q;
            cmp_s1_q <= i_comparator0_trig;
            cmp_s2_q <= cmp_s1_q;
            cmp1_s1_q <= i_comparator1_trig;
            cmp1_s2_q <= cmp1_s1_q;
            ck_s1_q <= i_counter_clk;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            ev_q <= ev_d;
            es_q <= es_d;
            // outputs held low: waveforms are not produced here
            o_out_positive <= 1'b0; // [R14]
            o_out_negative <= 1'b0; // [R14]
            if (o_running && ck_fall)
                o_count <= o_count + `CNT_ONE; // [R18]
            // clears first so that a simultaneous set wins below
            if (i_capture_a_irq_clr || i_capture_a_read)
                o_capture_a_irq <= 1'b0; // [R19]
            if (i_capture_b_irq_clr || i_capture_b_read)
                o_capture_b_irq <= 1'b0; // [R19]
            if (i_capture_a_read)
                o_capture_a_flag <= 1'b0; // [R21]
            if (i_capture_b_read)
                o_capture_b_flag <= 1'b0; // [R21]
            if (i_trig_stop_irq_clr)
                o_trig_stop_irq <= 1'b0;
            if (i_estop_clr)
                o_estop_irq <= 1'b0;
            if (i_estop_en && es_rise) begin
                o_running <= 1'b0; // [R12] [R14]
                o_estop_irq <= 1'b1;
            end else if (i_trig_op_en && !o_estop_irq) begin // [R05]
                if (o_running && i_trig_stop_en && stop_edge) begin
                    o_running <= 1'b0; // [R03] [R08]
                    if (i_trig_stop_irq_en)
                        o_trig_stop_irq <= 1'b1; // [R08]
                    if (cap_mode) begin
                        o_capture_a_reg <= o_count; // [R09] [R20]
                        o_capture_a_flag <= 1'b1; // [R21]
                        o_capture_a_irq <= 1'b1;
                        skip_b_q <= i_one_shot_sel; // [R11]
                    end
                end else if (!o_running && i_trig_start_en && start_edge) begin
                    o_running <= 1'b1; // [R03] [R06] [R10]
                    o_count <= `CNT_ZERO;
                end
                if (cap_mode && o_running && ev_fall) begin
                    if (skip_b_q)
                        skip_b_q <= 1'b0; // [R11]
                    else begin
                        o_capture_b_reg <= o_count; // [R07] [R10] [R20]
                        o_capture_b_flag <= 1'b1; // [R21]
                        o_capture_b_irq <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* test/capture_trigger_control_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module capture_trigger_checker (
    input wire logic i_clk, i_resetn, i_trig_op_en, i_trig_stop_irq_en, i_capture_a_read, o_estop_irq,
    input wire logic o_running, o_capture_a_flag, o_trig_stop_irq, o_out_positive, o_out_negative,
    input wire logic [15:0] o_count
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_out_low: assert property (!o_out_positive && !o_out_negative) else $error("out");
    a_start_en: assert property ($rose(o_running) |-> $past(i_trig_op_en)) else $error("start");
    a_start_zero: assert property ($rose(o_running) |-> o_count == 16'h0000) else $error("zero");
    a_stop_cap: assert property ($fell(o_running) && !o_estop_irq |-> o_capture_a_flag) else $error("cap");
    a_stop_irq: assert property ($fell(o_running) && !o_estop_irq && i_trig_stop_irq_en |-> o_trig_stop_irq)
        else $error("irq");
    a_estop_halt: assert property (o_estop_irq |=> !o_running) else $error("halt");
    a_read_a: assert property (i_capture_a_read |=> !o_capture_a_flag || $fell(o_running)) else $error("rd");
    a_idle_hold: assert property (!o_running ##1 !o_running |-> $stable(o_count)) else $error("hold");
    c_stop: cover property ($fell(o_running));
    c_start: cover property ($rose(o_running));
    c_estop: cover property ($rose(o_estop_irq));
endmodule
bind capture_trigger_control capture_trigger_checker chk_u (.*);
`default_nettype wire

/* test/pulse_source.sv */
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    input wire logic i_clk,
    output logic o_line = 1'h0,
    output logic o_counter_clk
);
    // starts mid low phase so reset release never sees a half pulse
    logic [4:0] c_q = 5'h0c;
    assign o_counter_clk = c_q[1];
    always @(posedge i_clk) begin
        c_q <= (c_q == 5'h13) ? 5'h00 : c_q + 5'h01;
        // edges midway between counter steps, so sync skew cannot move a count
        if (c_q[1:0] == 2'h1) o_line <= c_q < 5'h0b;
    end
endmodule
`default_nettype wire

/* test/capture_trigger_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module capture_trigger_control_tb;
    logic i_clk = 1'h0, i_resetn = 1'h0, i_ce = 1'h1, i_one_shot_sel = 1'h0, i_trig_src_group_sel = 1'h0;
    logic i_trig_start_en = 1'h1, i_trig_stop_en = 1'h1, i_trig_op_en = 1'h1, i_trig_stop_irq_en = 1'h1;
    logic i_estop_en = 1'h0;
    logic [1:0] i_counter_mode_field = 2'h1, i_trig_edge_mode = 2'h0, i_estop_src_sel = 2'h0;
    logic [3:0] es = 4'h0, i_unit_trig = 4'h0;
    logic [4:0] i_trig_src_code = 5'h00;
    logic [5:0] stb = 6'h00;
    logic [7:0] i_timer_irq_trig = 8'h00;
    wire logic i_counter_clk, line, i_comparator0_trig = es[0], i_comparator1_trig = es[1];
    wire logic i_capture_a_irq_clr = stb[0], i_capture_b_irq_clr = stb[1], i_capture_a_read = stb[2];
    wire logic i_capture_b_read = stb[3], i_trig_stop_irq_clr = stb[4], i_estop_clr = stb[5];
    // pulse train kept off line 0 while emergency stop is tested there
    wire logic [7:0] i_ext_irq_trig = {3'h0, es[3], 3'h0, (line & ~i_estop_en) | es[2]};
    wire logic [15:0] o_capture_a_reg, o_capture_b_reg, o_count;
    wire logic o_capture_a_flag, o_capture_b_flag, o_capture_a_irq, o_capture_b_irq, o_trig_stop_irq, o_estop_irq;
    wire logic o_running, o_out_positive, o_out_negative;
    integer mismatches = 0, n_compared = 0, k;
    initial forever #5 i_clk = ~i_clk;
    pulse_source src_u (.i_clk(i_clk), .o_line(line), .o_counter_clk(i_counter_clk));
    capture_trigger_control dut_u (.*);
    task tick(input integer n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task chk(input [63:0] name, input [15:0] seen, exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task strobe(input [5:0] m);
        @(posedge i_clk) stb <= m;
        @(posedge i_clk) stb <= 6'h00;
        #1;
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wait_a;
        for (k = 0; k < 200 && o_capture_a_flag !== 1'h1; k = k + 1) tick(1);
        if (k == 200) begin
            mismatches = mismatches + 1;
            results;
        end
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'h1;
        wait_a;
        chk("cap_a", o_capture_a_reg, 16'h0005);
        chk("cap_b", o_capture_b_reg, 16'h0003);
        chk("stop_irq", o_trig_stop_irq, 1'h1);
        strobe(6'h03);
        chk("irq_a", o_capture_a_irq, 1'h0);
        chk("flag_a", o_capture_a_flag, 1'h1);
        strobe(6'h0c);
        wait_a;
        chk("flag_b", o_capture_b_flag, 1'h1);
        $display("auto done");
        @(posedge i_clk) i_one_shot_sel <= 1'h1;
        strobe(6'h0c);
        wait_a;
        strobe(6'h0c);
        wait_a;
        chk("flag_b", o_capture_b_flag, 1'h0);
        $display("single done");
        @(posedge i_clk) i_trig_op_en <= 1'h0;
        strobe(6'h0c);
        tick(60);
        chk("flag_a", o_capture_a_flag, 1'h0);
        $display("disable done");
        @(posedge i_clk) i_trig_op_en <= 1'h1;
        i_estop_en <= 1'h1;
        i_trig_src_group_sel <= 1'h1;
        for (k = 0; k < 4; k = k + 1) begin
            // unit trigger starts the counter so the halt is really seen
            @(posedge i_clk) i_unit_trig <= 4'h1;
            tick(2);
            chk("run", o_running, 1'h1);
            // comparator lines stand for sampled comparator outputs
            @(posedge i_clk) es <= 4'h1 << k;
            i_estop_src_sel <= k[1:0];
            tick(6);
            chk("estop", o_estop_irq, 1'h1);
            chk("run", o_running, 1'h0);
            @(posedge i_clk) es <= 4'h0;
            i_unit_trig <= 4'h0;
            strobe(6'h20);
            chk("estop", o_estop_irq, 1'h0);
        end
        $display("estop done");
        results;
    end
endmodule
`default_nettype wire
